// >>> core/smsp_port.sv
// Operation
// - Phase 0: sample leading, change trailing
// - Phase 1: change leading, sample trailing
// - Master rate codes divide system clock
// - Codes 110/111 use overflow rates over six
// - Transfer end sets done flag, write-one clears
// - Select low as master sets done flag
// - Write while holding full sets collision flag
// - Holding flag set on write, cleared on move
// - Busy while transferring or shift register full
// - Master collision sets mode fault, write-one clears
// - Data address: writes transmit, reads receive
// - Daisy bit makes slave echo received byte
// - Pin map bit selects default or alternate pins
// - Port disabled releases all pins
// - Bit order: zero msb first, one lsb
// - Polarity sets idle level and leading edge
// - Colliding write is discarded
`timescale 1ns/1ps
module smsp_port
    import smsp_pkg::*;
#(
    parameter int RX_DEPTH = 2
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input smsp_pkg::smsp_sfr_req_type sfr_req,
    output logic [7:0] sfr_rdata_q,
    // Overflow pulses from timer 0 and the UART baud generator
    input wire logic uart_baud_overflow,
    input wire logic timer_zero_overflow,
    // Port event level toward the interrupt controller
    output logic port_event_q,
    // Default pin set
    input smsp_pkg::smsp_pins_type pins_a_in,
    output smsp_pkg::smsp_pins_type pins_a_out_q,
    output smsp_pkg::smsp_pins_type pins_a_oe_q,
    // Alternate pin set
    input smsp_pkg::smsp_pins_type pins_b_in,
    output smsp_pkg::smsp_pins_type pins_b_out_q,
    output smsp_pkg::smsp_pins_type pins_b_oe_q
);
    import smsp_pkg::*;

    function automatic logic [5:0] rate_half(input logic [2:0] code);
        case (code)
            3'h0: rate_half = 6'h02;
            3'h1: rate_half = 6'h04;
            3'h2: rate_half = 6'h08;
            3'h3: rate_half = 6'h10;
            3'h4: rate_half = 6'h20;
            3'h5: rate_half = 6'h01;
            default: rate_half = OVERFLOW_HALF;
        endcase
    endfunction : rate_half

    function automatic logic front_bit(input logic [7:0] v, input logic lsb_first);
        front_bit = lsb_first ? v[0] : v[7];
    endfunction : front_bit

    logic [7:0] control_q;
    logic rate_two_q;
    logic daisy_q;
    logic pin_map_q;
    logic done_q, collision_q, fault_q;
    logic [7:0] hold_q;
    logic hold_full_q;
    logic [7:0] osr_q;
    logic osr_full_q;
    logic [7:0] sh_q, sh_d;
    logic dout_q;
    logic sck_q;
    logic [3:0] edge_q;
    logic [2:0] bit_q;
    logic [5:0] div_q;
    smsp_state_type state_q;
    smsp_pins_type sync1_q, sync2_q;
    logic sck_prev_q;
    logic [7:0] rx_mem [RX_DEPTH];
    logic [$clog2(RX_DEPTH)-1:0] rx_wr_q, rx_rd_q;
    logic [$clog2(RX_DEPTH):0] rx_count_q;

    logic enable, is_master, ignore_sel, lsb_first, polarity, phase;
    logic [2:0] rate_code;
    logic selected, fault;
    logic tick, half_tick, lead_ev, trail_ev, sample_ev, shift_ev, din;
    logic start_master, start_slave, xfer_done, slave_abort, move_hold;
    logic wr_status, wr_data, rd_data;
    logic rx_push, rx_ready, rx_pop;
    logic [7:0] rx_byte;
    smsp_pins_type pin_in, role_out, role_oe;

    assign enable = control_q[CTL_PORT_ENABLE];
    assign is_master = control_q[CTL_MASTER];
    assign ignore_sel = control_q[CTL_SELECT_IGNORE];
    assign lsb_first = control_q[CTL_BIT_ORDER];
    assign polarity = control_q[CTL_POLARITY];
    assign phase = control_q[CTL_PHASE];
    assign rate_code = {rate_two_q, control_q[CTL_RATE_ONE], control_q[CTL_RATE_ZERO]};

    assign wr_status = sfr_req.wr && sfr_req.addr == ADDR_STATUS;
    assign wr_data = sfr_req.wr && sfr_req.addr == ADDR_DATA;
    assign rd_data = sfr_req.rd && sfr_req.addr == ADDR_DATA;

    // Pin map mux ahead of the synchroniser
    assign pin_in = pin_map_q ? pins_b_in : pins_a_in;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_q <= '1;
            sync2_q <= '1;
            sck_prev_q <= 1'b1;
        end
        else
        begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            sck_prev_q <= sync2_q.sck;
        end
    end

    assign selected = ignore_sel || !sync2_q.ss;
    assign fault = enable && is_master && !ignore_sel && !sync2_q.ss;

    // Serial clock divider for master mode
    assign tick = (rate_code[2:1] == 2'b11) ?
        (rate_code[0] ? timer_zero_overflow : uart_baud_overflow) : 1'b1;
    assign half_tick = state_q == ENG_MASTER && tick && div_q == rate_half(rate_code) - 6'h01;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            div_q <= '0;
        else if (state_q != ENG_MASTER || half_tick)
            div_q <= '0;
        else if (tick)
            div_q <= div_q + 6'h01;
    end

    // Edge events: even half edges lead, odd ones trail
    always_comb
    begin
        lead_ev = 1'b0;
        trail_ev = 1'b0;
        if (state_q == ENG_MASTER)
        begin
            lead_ev = half_tick && !edge_q[0];
            trail_ev = half_tick && edge_q[0];
        end
        else if (state_q == ENG_SLAVE)
        begin
            lead_ev = sck_prev_q == polarity && sync2_q.sck != polarity;
            trail_ev = sck_prev_q != polarity && sync2_q.sck == polarity;
        end
    end

    assign sample_ev = phase ? trail_ev : lead_ev;
    assign shift_ev = phase ? lead_ev : trail_ev;
    assign din = (state_q == ENG_MASTER) ? sync2_q.miso : sync2_q.mosi;
    assign sh_d = lsb_first ? {din, sh_q[7:1]} : {sh_q[6:0], din};

    assign rx_ready = rx_count_q != RX_DEPTH[$clog2(RX_DEPTH):0];
    assign start_master = state_q == ENG_IDLE && enable && is_master && !fault && osr_full_q && rx_ready;
    assign start_slave = state_q == ENG_IDLE && enable && !is_master && selected;
    assign slave_abort = state_q == ENG_SLAVE && (!enable || !selected);
    assign xfer_done = (state_q == ENG_MASTER && half_tick && edge_q == LAST_HALF_EDGE) ||
        (state_q == ENG_SLAVE && sample_ev && bit_q == LAST_BIT);
    assign move_hold = hold_full_q && !osr_full_q;

    // Shift engine
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ENG_IDLE;
            sh_q <= DATA_RESET;
            osr_q <= DATA_RESET;
            osr_full_q <= 1'b0;
            dout_q <= 1'b0;
            sck_q <= 1'b0;
            edge_q <= '0;
            bit_q <= '0;
        end
        else
        begin
            if (move_hold)
            begin
                osr_q <= hold_q;
                osr_full_q <= 1'b1;
            end
            case (state_q)
                ENG_IDLE:
                begin
                    sck_q <= polarity;
                    edge_q <= '0;
                    bit_q <= '0;
                    if (start_master || start_slave)
                    begin
                        state_q <= start_master ? ENG_MASTER : ENG_SLAVE;
                        if (osr_full_q)
                        begin
                            sh_q <= osr_q;
                            osr_full_q <= 1'b0;
                            dout_q <= front_bit(osr_q, lsb_first);
                        end
                        else
                            dout_q <= front_bit(sh_q, lsb_first);
                    end
                end
                ENG_MASTER:
                begin
                    if (fault)
                        state_q <= ENG_IDLE;
                    else
                    begin
                        if (half_tick)
                        begin
                            sck_q <= ~sck_q;
                            edge_q <= edge_q + 4'h1;
                        end
                        if (sample_ev)
                            sh_q <= sh_d;
                        if (shift_ev)
                            dout_q <= front_bit(sh_q, lsb_first);
                        if (xfer_done)
                            state_q <= ENG_IDLE;
                    end
                end
                ENG_SLAVE:
                begin
                    if (slave_abort)
                        state_q <= ENG_IDLE;
                    else
                    begin
                        if (sample_ev)
                        begin
                            sh_q <= sh_d;
                            bit_q <= bit_q + 3'h1;
                        end
                        if (shift_ev)
                            dout_q <= front_bit(sh_q, lsb_first);
                        if (xfer_done)
                        begin
                            state_q <= ENG_IDLE;
                            if (daisy_q)
                            begin
                                osr_q <= sh_d;
                                osr_full_q <= 1'b1;
                            end
                        end
                    end
                end
                default: state_q <= ENG_IDLE;
            endcase
        end
    end

    // Transmit holding register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_q <= DATA_RESET;
            hold_full_q <= 1'b0;
        end
        else if (wr_data && !hold_full_q)
        begin
            hold_q <= sfr_req.wdata;
            hold_full_q <= 1'b1;
        end
        else if (move_hold)
            hold_full_q <= 1'b0;
    end

    // Sticky flags; a hardware set beats a same-cycle clear
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done_q <= 1'b0;
            collision_q <= 1'b0;
            fault_q <= 1'b0;
        end
        else
        begin
            if (xfer_done || fault)
                done_q <= 1'b1;
            else if (wr_status && sfr_req.wdata[ST_DONE])
                done_q <= 1'b0;
            if (wr_data && hold_full_q)
                collision_q <= 1'b1;
            else if (wr_status && sfr_req.wdata[ST_COLLISION])
                collision_q <= 1'b0;
            if (fault)
                fault_q <= 1'b1;
            else if (wr_status && sfr_req.wdata[ST_FAULT])
                fault_q <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            control_q <= CONTROL_RESET;
            rate_two_q <= 1'b0;
            daisy_q <= 1'b0;
            pin_map_q <= 1'b0;
        end
        else
        begin
            if (fault)
                control_q[CTL_MASTER] <= 1'b0;
            else if (sfr_req.wr && sfr_req.addr == ADDR_CONTROL)
                control_q <= sfr_req.wdata;
            if (wr_status)
                rate_two_q <= sfr_req.wdata[ST_RATE_TWO];
            if (sfr_req.wr && sfr_req.addr == ADDR_OUTPUT_CTRL)
                daisy_q <= sfr_req.wdata[DAISY_BIT];
            if (sfr_req.wr && sfr_req.addr == ADDR_PIN_SELECT)
                pin_map_q <= sfr_req.wdata[PIN_MAP_BIT];
        end
    end

    // Two-entry receive buffer; full stalls the master's next start
    assign rx_push = xfer_done && rx_ready;
    // Master phase 0 ends on a trailing edge, after the last sample is already in
    assign rx_byte = sample_ev ? sh_d : sh_q;
    assign rx_pop = rd_data && rx_count_q != '0;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_wr_q <= '0;
            rx_rd_q <= '0;
            rx_count_q <= '0;
        end
        else
        begin
            if (rx_push)
                rx_wr_q <= rx_wr_q + 1'b1;
            if (rx_pop)
                rx_rd_q <= rx_rd_q + 1'b1;
            if (rx_push && !rx_pop)
                rx_count_q <= rx_count_q + 1'b1;
            else if (rx_pop && !rx_push)
                rx_count_q <= rx_count_q - 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rx_push)
            rx_mem[rx_wr_q] <= rx_byte;
    end

    // Register read data
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            sfr_rdata_q <= 8'h00;
        else if (sfr_req.rd)
        begin
            case (sfr_req.addr)
                ADDR_STATUS: sfr_rdata_q <= {done_q, collision_q, hold_full_q,
                    state_q != ENG_IDLE || osr_full_q, fault_q, 2'b00, rate_two_q};
                ADDR_CONTROL: sfr_rdata_q <= control_q;
                ADDR_DATA: sfr_rdata_q <= rx_count_q != '0 ? rx_mem[rx_rd_q] : 8'h00;
                ADDR_PIN_SELECT: sfr_rdata_q <= 8'(pin_map_q) << PIN_MAP_BIT;
                ADDR_OUTPUT_CTRL: sfr_rdata_q <= 8'(daisy_q) << DAISY_BIT;
                default: sfr_rdata_q <= 8'h00;
            endcase
        end
    end

    // Pin roles: master drives clock and data out, slave drives data in
    always_comb
    begin
        role_out = '0;
        role_oe = '0;
        role_out.sck = (state_q == ENG_IDLE) ? polarity : sck_q;
        role_out.mosi = dout_q;
        role_out.miso = dout_q;
        if (enable)
        begin
            if (is_master)
            begin
                role_oe.sck = 1'b1;
                role_oe.mosi = 1'b1;
            end
            else
                role_oe.miso = selected;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pins_a_out_q <= '0;
            pins_a_oe_q <= '0;
            pins_b_out_q <= '0;
            pins_b_oe_q <= '0;
            port_event_q <= 1'b0;
        end
        else
        begin
            pins_a_out_q <= role_out;
            pins_b_out_q <= role_out;
            pins_a_oe_q <= pin_map_q ? '0 : role_oe;
            pins_b_oe_q <= pin_map_q ? role_oe : '0;
            port_event_q <= done_q || fault_q;
        end
    end
endmodule : smsp_port

// >>> core/smsp_pkg.sv
package smsp_pkg;
    // Register addresses on the special function register port
    localparam logic [11:0] ADDR_STATUS = 12'h084;
    localparam logic [11:0] ADDR_CONTROL = 12'h085;
    localparam logic [11:0] ADDR_DATA = 12'h086;
    localparam logic [11:0] ADDR_PIN_SELECT = 12'h0a4;
    localparam logic [11:0] ADDR_OUTPUT_CTRL = 12'h0a44;
    // Values after reset
    localparam logic [7:0] CONTROL_RESET = 8'h04;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // Control register fields
    localparam int CTL_SELECT_IGNORE = 7;
    localparam int CTL_PORT_ENABLE = 6;
    localparam int CTL_BIT_ORDER = 5;
    localparam int CTL_MASTER = 4;
    localparam int CTL_POLARITY = 3;
    localparam int CTL_PHASE = 2;
    localparam int CTL_RATE_ONE = 1;
    localparam int CTL_RATE_ZERO = 0;
    // Status register fields
    localparam int ST_DONE = 7;
    localparam int ST_COLLISION = 6;
    localparam int ST_HOLDING = 5;
    localparam int ST_BUSY = 4;
    localparam int ST_FAULT = 3;
    localparam int ST_RATE_TWO = 0;
    // Auxiliary register fields
    localparam int DAISY_BIT = 4;
    localparam int PIN_MAP_BIT = 4;
    // Transfer shape and overflow-driven half period
    localparam logic [3:0] LAST_HALF_EDGE = 4'hf;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [5:0] OVERFLOW_HALF = 6'h03;
    typedef struct packed {
        logic ss;
        logic mosi;
        logic miso;
        logic sck;
    } smsp_pins_type;
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } smsp_sfr_req_type;
    typedef enum logic [1:0] {
        ENG_IDLE,
        ENG_MASTER,
        ENG_SLAVE
    } smsp_state_type;
endpackage : smsp_pkg

// >>> test/smsp_port_checker.sv
`timescale 1ns/1ps
module smsp_port_checker
    import smsp_pkg::*;
#(
    parameter int RX_DEPTH = 2
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port, overflow pulses and event
    input smsp_pkg::smsp_sfr_req_type sfr_req,
    input wire logic [7:0] sfr_rdata_q,
    input wire logic uart_baud_overflow,
    input wire logic timer_zero_overflow,
    input wire logic port_event_q,
    // Pin sets
    input smsp_pkg::smsp_pins_type pins_a_in,
    input smsp_pkg::smsp_pins_type pins_a_out_q,
    input smsp_pkg::smsp_pins_type pins_a_oe_q,
    input smsp_pkg::smsp_pins_type pins_b_in,
    input smsp_pkg::smsp_pins_type pins_b_out_q,
    input smsp_pkg::smsp_pins_type pins_b_oe_q
);
    localparam int HALF [6] = '{2, 4, 8, 16, 32, 1};
    logic [7:0] ctl_q;
    logic rate_two_q;
    logic [5:0] gap_q;
    logic [2:0] rate;
    assign rate = {rate_two_q, ctl_q[1:0]};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Shadow of the mode bits software wrote
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
            ctl_q <= CONTROL_RESET;
        else if (sfr_req.wr && sfr_req.addr == ADDR_CONTROL)
            ctl_q <= sfr_req.wdata;
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
            rate_two_q <= 1'b0;
        else if (sfr_req.wr && sfr_req.addr == ADDR_STATUS)
            rate_two_q <= sfr_req.wdata[ST_RATE_TWO];
    // Cycles since the serial clock last moved, saturating
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
            gap_q <= 6'h3f;
        else if ($changed(pins_a_out_q.sck))
            gap_q <= 6'h00;
        else if (gap_q != 6'h3f)
            gap_q <= gap_q + 6'h01;
    a_one_pin_set: assert property (!(|pins_a_oe_q && |pins_b_oe_q))
        else $error("both pin sets enabled");
    a_select_undriven: assert property (!pins_a_oe_q.ss && !pins_b_oe_q.ss)
        else $error("select pin driven");
    a_disabled_released: assert property (!ctl_q[CTL_PORT_ENABLE] && !$past(ctl_q[CTL_PORT_ENABLE])
        && !$past(ctl_q[CTL_PORT_ENABLE], 2) |-> pins_a_oe_q == '0 && pins_b_oe_q == '0)
        else $error("disabled port still drives");
    a_idle_polarity: assert property ($rose(pins_a_oe_q.sck) |-> pins_a_out_q.sck == ctl_q[CTL_POLARITY])
        else $error("clock idle level wrong");
    a_sample_stable: assert property (pins_a_oe_q.sck && $changed(pins_a_out_q.sck)
        && ((pins_a_out_q.sck != ctl_q[CTL_POLARITY]) ^ ctl_q[CTL_PHASE]) |-> $stable(pins_a_out_q.mosi))
        else $error("data moved on sample edge");
    a_rate_spacing: assert property (pins_a_oe_q.sck && $changed(pins_a_out_q.sck) && rate < 3'h6
        && pins_a_out_q.sck != ctl_q[CTL_POLARITY] |-> gap_q >= 6'(HALF[rate] - 1))
        else $error("serial clock too fast");
    a_fault_turn: assert property ((pins_a_oe_q.sck && !ctl_q[CTL_SELECT_IGNORE] && !pins_a_in.ss) [*3]
        |-> ##[0:4] (!pins_a_oe_q.sck && pins_a_oe_q.miso))
        else $error("pins not turned on fault");
    a_fault_event: assert property ($fell(pins_a_oe_q.sck) && pins_a_oe_q.miso |-> ##[0:3] port_event_q)
        else $error("no event on mode fault");
    a_rdata_hold: assert property (!sfr_req.rd |=> $stable(sfr_rdata_q))
        else $error("read data moved without read");
endmodule : smsp_port_checker

bind smsp_port smsp_port_checker #(.RX_DEPTH(RX_DEPTH)) u_checker (.mclk(mclk), .rst_n(rst_n), .sfr_req(sfr_req),
    .sfr_rdata_q(sfr_rdata_q), .uart_baud_overflow(uart_baud_overflow), .timer_zero_overflow(timer_zero_overflow),
    .port_event_q(port_event_q), .pins_a_in(pins_a_in), .pins_a_out_q(pins_a_out_q), .pins_a_oe_q(pins_a_oe_q),
    .pins_b_in(pins_b_in), .pins_b_out_q(pins_b_out_q), .pins_b_oe_q(pins_b_oe_q));

// >>> test/smsp_slave_model.sv
`timescale 1ns/1ps
module smsp_slave_model
(
    // Serial lines
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    // Mode and payload
    input wire logic clock_polarity,
    input wire logic clock_phase,
    input wire logic sel,
    input wire logic [7:0] tx,
    output logic [7:0] rx
);
    logic [7:0] sh = 8'h00;
    initial miso = 1'b0;
    initial rx = 8'h00;
    // Released line keeps changing so a stale bit never reads as data
    always #7
        if (!sel)
            miso = ~miso;
    always @(posedge sel)
    begin
        sh = tx;
        if (!clock_phase)
        begin
            miso = sh[7];
            sh = sh << 1;
        end
    end
    // Leading edge is the move away from the idle level
    always @(sck)
        if (sel)
        begin
            if ((sck !== clock_polarity) ^ clock_phase)
                rx = {rx[6:0], mosi};
            else
            begin
                miso = sh[7];
                sh = sh << 1;
            end
        end
endmodule : smsp_slave_model

// >>> test/spi_master_slave_port_test.sv
`timescale 1ns/1ps
module spi_master_slave_port_test;
    import smsp_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    smsp_sfr_req_type req = '0;
    logic uof = 1'b0;
    logic tof = 1'b0;
    logic slave_select_n = 1'b1;
    logic [7:0] rdata;
    logic port_event;
    smsp_pins_type ai;
    smsp_pins_type ao;
    smsp_pins_type aoe;
    smsp_pins_type bo;
    smsp_pins_type boe;
    logic pol = 1'b0;
    logic pha = 1'b0;
    logic sel = 1'b0;
    logic [7:0] ptx = 8'h3c;
    logic [7:0] prx;
    logic pmiso;
    logic [3:0] cyc = 4'h0;
    int bad_count = 0;
    int n_compared = 0;
    always #5 mclk = ~mclk;
    // Overflow pulses: baud every 4 cycles, timer every 2
    always @(negedge mclk)
    begin
        cyc <= cyc + 4'h1;
        uof <= (cyc[1:0] == 2'h0);
        tof <= cyc[0];
    end
    // Undriven clock and mosi lines show the inverse of the current output register value; undriven miso shows the partner
    assign ai = '{ss: slave_select_n, mosi: aoe.mosi ? ao.mosi : ~ao.mosi,
        miso: aoe.miso ? ao.miso : pmiso, sck: aoe.sck ? ao.sck : ~ao.sck};
    smsp_port DUT (.mclk(mclk), .rst_n(rst_n), .sfr_req(req), .sfr_rdata_q(rdata), .uart_baud_overflow(uof),
        .timer_zero_overflow(tof), .port_event_q(port_event), .pins_a_in(ai), .pins_a_out_q(ao),
        .pins_a_oe_q(aoe), .pins_b_in(4'h8), .pins_b_out_q(bo), .pins_b_oe_q(boe));
    smsp_slave_model partner (.sck(ai.sck), .mosi(ai.mosi), .miso(pmiso), .clock_polarity(pol), .clock_phase(pha), .sel(sel),
        .tx(ptx), .rx(prx));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge mclk);
        req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge mclk);
        req.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(negedge mclk);
        req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge mclk);
        req.rd = 1'b0;
        d = rdata;
    endtask : rd
    task automatic rchk(input string what, input logic [11:0] a, input logic [7:0] m, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(what, d & m, exp);
    endtask : rchk
    task automatic wait_done();
        logic [7:0] d = 8'h00;
        for (int i = 0; i < 3000 && d[ST_DONE] !== 1'b1; i++)
            rd(ADDR_STATUS, d);
        chk("done flag", d & 8'h80, 8'h80);
        wr(ADDR_STATUS, 8'h80);
    endtask : wait_done
    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
            rev[i] = v[7 - i];
    endfunction : rev
    task automatic t_reset();
        rchk("status reset", ADDR_STATUS, 8'hf1, 8'h00);
        rchk("control reset", ADDR_CONTROL, 8'hff, CONTROL_RESET);
        rchk("data reset", ADDR_DATA, 8'hff, DATA_RESET);
        rchk("pin reset", ADDR_PIN_SELECT, 8'h10, 8'h00);
        rchk("aux reset", ADDR_OUTPUT_CTRL, 8'h10, 8'h00);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_modes();
        logic [7:0] d;
        for (int i = 0; i < 5; i++)
        begin
            pol = i[0];
            pha = i[1];
            d = 8'ha1 + 8'(i);
            wr(ADDR_CONTROL, {1'b0, 1'b1, i[2], 1'b1, pol, pha, 2'b01});
            // Clock pin settles to its new idle level before the partner listens
            repeat (2) @(negedge mclk);
            sel = 1'b1;
            wr(ADDR_DATA, d);
            wait_done();
            sel = 1'b0;
            chk("partner byte", prx, i[2] ? rev(d) : d);
            rchk("received byte", ADDR_DATA, 8'hff, i[2] ? rev(ptx) : ptx);
            rchk("status idle", ADDR_STATUS, 8'hff, 8'h00);
            chk("idle clock", {7'h00, ao.sck}, {7'h00, pol});
        end
        $display("t_modes done");
    endtask : t_modes
    task automatic t_rate();
        int half [8] = '{2, 4, 8, 16, 32, 1, 12, 6};
        int n;
        logic [7:0] d;
        for (int c = 0; c < 8; c++)
        begin
            wr(ADDR_STATUS, {7'h00, c[2]});
            wr(ADDR_CONTROL, {6'h14, c[1:0]});
            wr(ADDR_DATA, 8'h5a);
            for (n = 0; ao.sck !== 1'b1 && n < 600; n++)
                @(negedge mclk);
            for (n = 0; ao.sck === 1'b1 && n < 600; n++)
                @(negedge mclk);
            chk("half period", 8'(n), 8'(half[c]));
            wait_done();
            rd(ADDR_DATA, d);
        end
        $display("t_rate done");
    endtask : t_rate
    task automatic t_collide();
        wr(ADDR_STATUS, 8'h00);
        wr(ADDR_CONTROL, 8'h53);
        sel = 1'b1;
        wr(ADDR_DATA, 8'hc3);
        repeat (3) @(negedge mclk);
        rchk("moved to shifter", ADDR_STATUS, 8'h30, 8'h10);
        wr(ADDR_DATA, 8'h81);
        wr(ADDR_DATA, 8'h7e);
        wr(ADDR_DATA, 8'h99);
        rchk("collision status", ADDR_STATUS, 8'hff, 8'h70);
        wait_done();
        wait_done();
        chk("partner bytes", prx, 8'h81);
        // Receive buffer is full; this read lets the held byte start
        rchk("first received", ADDR_DATA, 8'hff, ptx);
        wait_done();
        sel = 1'b0;
        chk("held byte sent", prx, 8'h7e);
        rchk("collision kept", ADDR_STATUS, 8'h40, 8'h40);
        wr(ADDR_STATUS, 8'h40);
        rchk("status clear", ADDR_STATUS, 8'hff, 8'h00);
        rchk("second received", ADDR_DATA, 8'hff, 8'h00);
        rchk("third received", ADDR_DATA, 8'hff, 8'h00);
        $display("t_collide done");
    endtask : t_collide
    task automatic t_fault();
        wr(ADDR_CONTROL, 8'h50);
        repeat (4) @(negedge mclk);
        slave_select_n = 1'b0;
        repeat (10) @(negedge mclk);
        rchk("fault status", ADDR_STATUS, 8'hef, 8'h88);
        chk("event level", {7'h00, port_event}, 8'h01);
        rchk("master dropped", ADDR_CONTROL, 8'hff, 8'h40);
        chk("pin enables", {4'h0, aoe}, 8'h02);
        slave_select_n = 1'b1;
        rchk("fault held", ADDR_STATUS, 8'h08, 8'h08);
        wr(ADDR_STATUS, 8'h88);
        rchk("fault clear", ADDR_STATUS, 8'hff, 8'h00);
        $display("t_fault done");
    endtask : t_fault
    task automatic t_pins();
        wr(ADDR_PIN_SELECT, 8'h10);
        wr(ADDR_CONTROL, 8'h50);
        repeat (4) @(negedge mclk);
        chk("alternate enables", {boe, aoe}, 8'h50);
        rchk("pin select", ADDR_PIN_SELECT, 8'h10, 8'h10);
        wr(ADDR_CONTROL, 8'h10);
        repeat (4) @(negedge mclk);
        chk("disabled enables", {boe, aoe}, 8'h00);
        wr(ADDR_PIN_SELECT, 8'h00);
        wr(ADDR_OUTPUT_CTRL, 8'h10);
        rchk("daisy bit", ADDR_OUTPUT_CTRL, 8'h10, 8'h10);
        rchk("unmapped read", 12'h0ff, 8'hff, 8'h00);
        $display("t_pins done");
    endtask : t_pins
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    initial
    begin
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        t_reset();
        t_modes();
        t_rate();
        t_collide();
        t_fault();
        t_pins();
        end_of_test();
    end
    // Whole run needs well under 20000 cycles
    initial
    begin
        #500000;
        bad_count++;
        end_of_test();
    end
endmodule : spi_master_slave_port_test
